/* File: shared/bscrc_pkg.sv */
// package for the boot strap, clock ratio and reset front end
// assumes one 10 MHz system clock and a single AHB-Lite master
package bscrc_pkg;

	// register byte offsets on the AHB-Lite slave
	localparam logic [7:0] BSCRC_STATUS_OFS = 8'h00;
	localparam logic [7:0] BSCRC_RATIO_OFS = 8'h04;
	localparam logic [7:0] BSCRC_CTRL_OFS = 8'h08;

	// control register fields, both self-clearing request pulses
	localparam int BSCRC_CTRL_SOFT_WARM = 0;
	localparam int BSCRC_CTRL_SOFT_COLD = 1;

	// status register field positions
	localparam int BSCRC_ST_MEM_LSB = 0;
	localparam int BSCRC_ST_LB_LSB = 2;
	localparam int BSCRC_ST_PIPE_LSB = 4;
	localparam int BSCRC_ST_BYTE_ORDER = 7;
	localparam int BSCRC_ST_RESP_ORDER = 8;
	localparam int BSCRC_ST_CORE_RST = 9;
	localparam int BSCRC_ST_MEM_RST = 10;
	localparam int BSCRC_ST_PWR_GOOD = 11;
	localparam int BSCRC_ST_RSVD_CODE = 12;

	// ratio register field positions
	localparam int BSCRC_RT_MEM_LSB = 0;
	localparam int BSCRC_RT_VCO_LSB = 4;
	localparam int BSCRC_RT_LB_LSB = 8;
	localparam int BSCRC_RT_PIPE_LSB = 12;

	// strap codes
	localparam logic [1:0] BSCRC_MEM_DIV1 = 2'h0;
	localparam logic [1:0] BSCRC_MEM_DIV2 = 2'h1;
	localparam logic [1:0] BSCRC_MEM_DIV1P5 = 2'h2;
	localparam logic [1:0] BSCRC_LB_DIV9 = 2'h0;
	localparam logic [1:0] BSCRC_LB_DIV12 = 2'h1;
	localparam logic [1:0] BSCRC_LB_DIV15 = 2'h2;

	// decoded values; ratios in half steps, zero marks a reserved code
	localparam logic [2:0] BSCRC_HALF_DIV1 = 3'h2;
	localparam logic [2:0] BSCRC_HALF_DIV2 = 3'h4;
	localparam logic [2:0] BSCRC_HALF_DIV1P5 = 3'h3;
	localparam logic [2:0] BSCRC_VCO_X3 = 3'h3;
	localparam logic [2:0] BSCRC_VCO_X4 = 3'h4;
	localparam logic [3:0] BSCRC_LB_9 = 4'h9;
	localparam logic [3:0] BSCRC_LB_12 = 4'hc;
	localparam logic [3:0] BSCRC_LB_15 = 4'hf;
	localparam logic [3:0] BSCRC_PIPE_HALF_BASE = 4'h4;

	// captured boot straps
	typedef struct packed {
		logic [1:0] mem_ratio_strap;
		logic [1:0] localbus_ratio_strap;
		logic [2:0] pipe_ratio_strap;
		logic byte_order_strap;
		logic response_order_strap;
	} bscrc_straps_t;

	localparam bscrc_straps_t BSCRC_STRAPS_RST = '0;

	// decoded clock and mode settings handed to the rest of the chip
	typedef struct packed {
		logic [2:0] mem_half_ratio;
		logic [2:0] vco_mult;
		logic [3:0] lb_div;
		logic [3:0] pipe_half_ratio;
		logic big_endian;
		logic out_of_order_en;
		logic pcix_big_endian;
		logic reserved_code;
	} bscrc_clkcfg_t;

	localparam bscrc_clkcfg_t BSCRC_CLKCFG_RST = '0;

endpackage : bscrc_pkg

/* File: hw/bscrc_top.sv */
// boot strap capture, clock ratio decode and reset sequencing
// assumes pins are synchronous to sys_clk_i and one AHB-Lite master
`timescale 1ns/1ps
module bscrc_top
	import bscrc_pkg::*;
#(
	parameter int RST_SYNC_STAGES = 2
)
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic warm_reset_n_i,
	input wire logic full_init_reset_n_i,
	input wire logic power_good_i,
	input wire logic [1:0] mem_ratio_strap_i,
	input wire logic [1:0] localbus_ratio_strap_i,
	input wire logic [2:0] pipe_ratio_strap_i,
	input wire logic byte_order_strap_i,
	input wire logic response_order_strap_i,
	input wire logic timer_ext_clk_i,
	input wire logic mem_ref_clk_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	output logic core_reset_o,
	output logic mem_if_reset_o,
	output bscrc_clkcfg_t clk_cfg_o,
	output logic timer_count_clk_o,
	output logic mem_domain_clk_o
);

	// refuse a release chain too short to give a clean synchronised edge
	if (RST_SYNC_STAGES < 2)
	begin : g_bad_stages
		$error("RST_SYNC_STAGES must be at least 2");
	end

	// reset request and release chains
	logic soft_warm;
	logic soft_cold;
	logic cold_req;
	logic warm_req;
	logic [RST_SYNC_STAGES-1:0] core_chain;
	logic [RST_SYNC_STAGES-1:0] mem_chain;
	logic [RST_SYNC_STAGES-1:0] next_core_chain;
	logic [RST_SYNC_STAGES-1:0] next_mem_chain;
	wire logic [RST_SYNC_STAGES-1:0] core_shift;
	wire logic [RST_SYNC_STAGES-1:0] mem_shift;

	// release shift, one stage per bit; stage zero takes the released level
	for (genvar s = 0; s < RST_SYNC_STAGES; s++)
	begin : g_stage
		if (s == 0)
		begin : g_first
			assign core_shift[s] = 1'b0;
			assign mem_shift[s] = 1'b0;
		end
		else
		begin : g_rest
			assign core_shift[s] = core_chain[s-1];
			assign mem_shift[s] = mem_chain[s-1];
		end
	end

	// pin sampled active low; power good missing holds both domains
	always_comb
	begin
		cold_req = ~full_init_reset_n_i | ~power_good_i | soft_cold;
		warm_req = cold_req | ~warm_reset_n_i | soft_warm;
		next_core_chain = core_shift;
		next_mem_chain = mem_shift;
		if (warm_req)
		begin
			next_core_chain = '1;
		end
		if (cold_req)
		begin
			next_mem_chain = '1;
		end
	end

	// assertion loads the whole chain on the next edge, release walks the chain on the system clock
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			core_chain <= '1;
			mem_chain <= '1;
		end
		else
		begin
			core_chain <= next_core_chain;
			mem_chain <= next_mem_chain;
		end
	end

	assign core_reset_o = core_chain[RST_SYNC_STAGES-1];
	assign mem_if_reset_o = mem_chain[RST_SYNC_STAGES-1];

	// strap capture and decode
	bscrc_straps_t straps_pin;
	bscrc_straps_t straps;
	bscrc_straps_t next_straps;
	bscrc_clkcfg_t next_cfg;

	// a warm reset recaptures too, since straps are board constants anyway
	always_comb
	begin
		straps_pin.mem_ratio_strap = mem_ratio_strap_i;
		straps_pin.localbus_ratio_strap = localbus_ratio_strap_i;
		straps_pin.pipe_ratio_strap = pipe_ratio_strap_i;
		straps_pin.byte_order_strap = byte_order_strap_i;
		straps_pin.response_order_strap = response_order_strap_i;
		next_straps = straps;
		if (warm_req || core_reset_o)
		begin
			next_straps = straps_pin;
		end
	end

	// decode from held straps so a late pin change cannot move a ratio
	always_comb
	begin
		next_cfg = BSCRC_CLKCFG_RST;
		case (straps.mem_ratio_strap)
			BSCRC_MEM_DIV1:
			begin
				next_cfg.mem_half_ratio = BSCRC_HALF_DIV1;
				next_cfg.vco_mult = BSCRC_VCO_X3;
			end
			BSCRC_MEM_DIV2:
			begin
				next_cfg.mem_half_ratio = BSCRC_HALF_DIV2;
				next_cfg.vco_mult = BSCRC_VCO_X4;
			end
			BSCRC_MEM_DIV1P5:
			begin
				next_cfg.mem_half_ratio = BSCRC_HALF_DIV1P5;
				next_cfg.vco_mult = BSCRC_VCO_X3;
			end
			default:
			begin
				next_cfg.reserved_code = 1'b1; // zero ratio flags reserved code
			end
		endcase
		case (straps.localbus_ratio_strap)
			BSCRC_LB_DIV9: next_cfg.lb_div = BSCRC_LB_9;
			BSCRC_LB_DIV12: next_cfg.lb_div = BSCRC_LB_12;
			BSCRC_LB_DIV15: next_cfg.lb_div = BSCRC_LB_15;
			default: next_cfg.reserved_code = 1'b1;
		endcase
		next_cfg.pipe_half_ratio = BSCRC_PIPE_HALF_BASE
			+ {1'b0, straps.pipe_ratio_strap};
		next_cfg.big_endian = straps.byte_order_strap;
		next_cfg.pcix_big_endian = 1'b0;
		next_cfg.out_of_order_en = ~straps.response_order_strap;
	end

	// strap hold and decoded settings
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			straps <= BSCRC_STRAPS_RST;
			clk_cfg_o <= BSCRC_CLKCFG_RST;
		end
		else
		begin
			straps <= next_straps;
			clk_cfg_o <= next_cfg;
		end
	end

	logic next_timer_count_clk;
	logic next_mem_domain_clk;

	// clock routing; no divider here, the real derived clocks live elsewhere
	always_comb
	begin
		next_timer_count_clk = timer_ext_clk_i;
		next_mem_domain_clk = mem_ref_clk_i;
	end

	// sampled copies only, so edges are one system cycle late
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			timer_count_clk_o <= 1'b0;
			mem_domain_clk_o <= 1'b0;
		end
		else
		begin
			timer_count_clk_o <= next_timer_count_clk;
			mem_domain_clk_o <= next_mem_domain_clk;
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	logic ph_wr;
	logic [7:0] ph_addr;
	logic next_ph_wr;
	logic [7:0] next_ph_addr;
	logic next_soft_warm;
	logic next_soft_cold;
	logic [31:0] next_hrdata;
	logic addr_ok;
	logic addr_low;
	logic [31:0] status_word;
	logic [31:0] ratio_word;

	// read words built apart from the decode so each layout sits in one place
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[BSCRC_ST_MEM_LSB +: 2] = straps.mem_ratio_strap;
		status_word[BSCRC_ST_LB_LSB +: 2] = straps.localbus_ratio_strap;
		status_word[BSCRC_ST_PIPE_LSB +: 3] = straps.pipe_ratio_strap;
		status_word[BSCRC_ST_BYTE_ORDER] = straps.byte_order_strap;
		status_word[BSCRC_ST_RESP_ORDER] = straps.response_order_strap;
		status_word[BSCRC_ST_CORE_RST] = core_reset_o;
		status_word[BSCRC_ST_MEM_RST] = mem_if_reset_o;
		status_word[BSCRC_ST_PWR_GOOD] = power_good_i;
		status_word[BSCRC_ST_RSVD_CODE] = clk_cfg_o.reserved_code;
		ratio_word = 32'h0000_0000;
		ratio_word[BSCRC_RT_MEM_LSB +: 3] = clk_cfg_o.mem_half_ratio;
		ratio_word[BSCRC_RT_VCO_LSB +: 3] = clk_cfg_o.vco_mult;
		ratio_word[BSCRC_RT_LB_LSB +: 4] = clk_cfg_o.lb_div;
		ratio_word[BSCRC_RT_PIPE_LSB +: 4] = clk_cfg_o.pipe_half_ratio;
	end

	// address phase taken on hready; write lands in the following data phase
	always_comb
	begin
		addr_ok = hsel_i & htrans_i[1] & hready_i;
		addr_low = haddr_i[31:8] == 24'h00_0000; // upper aliases must not fire a soft reset
		next_ph_wr = addr_ok & hwrite_i & addr_low;
		next_ph_addr = addr_ok ? haddr_i[7:0] : 8'h00;
		next_soft_warm = 1'b0;
		next_soft_cold = 1'b0;
		if (ph_wr && ph_addr == BSCRC_CTRL_OFS)
		begin
			next_soft_warm = hwdata_i[BSCRC_CTRL_SOFT_WARM];
			next_soft_cold = hwdata_i[BSCRC_CTRL_SOFT_COLD];
		end
		next_hrdata = 32'h0000_0000;
		if (addr_ok && !hwrite_i && addr_low)
		begin
			case (haddr_i[7:0])
				BSCRC_STATUS_OFS: next_hrdata = status_word;
				BSCRC_RATIO_OFS: next_hrdata = ratio_word;
				default:
				begin
					next_hrdata = 32'h0000_0000; // unmapped and control read as zero
				end
			endcase
		end
	end

	// bus phase registers; soft requests last one cycle, the chain stretches them
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			ph_wr <= 1'b0;
			ph_addr <= 8'h00;
			soft_warm <= 1'b0;
			soft_cold <= 1'b0;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
		else
		begin
			ph_wr <= next_ph_wr;
			ph_addr <= next_ph_addr;
			soft_warm <= next_soft_warm;
			soft_cold <= next_soft_cold;
			hrdata_o <= next_hrdata;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

endmodule : bscrc_top

/* File: sim/bscrc_top_sva.sv */
// checker for the strap, clock ratio and reset front end
// assumes it is bound to bscrc_top and sees its ports only
`timescale 1ns/1ps
module bscrc_top_sva
	import bscrc_pkg::*;
#(
	parameter int RST_SYNC_STAGES = 2
)
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic warm_reset_n_i,
	input wire logic full_init_reset_n_i,
	input wire logic power_good_i,
	input wire logic timer_ext_clk_i,
	input wire logic mem_ref_clk_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic core_reset_o,
	input wire logic mem_if_reset_o,
	input wire bscrc_clkcfg_t clk_cfg_o,
	input wire logic timer_count_clk_o,
	input wire logic mem_domain_clk_o
);
	logic idle;
	// all three reset sources quiet
	assign idle = warm_reset_n_i && full_init_reset_n_i && power_good_i;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// two cycles out of reset, so the last capture has reached the outputs
	sequence settled;
		!core_reset_o && $past(!core_reset_o);
	endsequence
	sequence warm_only;
		!warm_reset_n_i && full_init_reset_n_i && power_good_i && !mem_if_reset_o;
	endsequence
	chk_warm_core: assert property (warm_only |=> core_reset_o && !mem_if_reset_o)
		else $error("warm reset touched memory interface");
	chk_cold_full: assert property (!full_init_reset_n_i |=> core_reset_o && mem_if_reset_o)
		else $error("cold reset did not reset all");
	chk_power_hold: assert property (!power_good_i |=> core_reset_o && mem_if_reset_o)
		else $error("reset released without power good");
	chk_release_sync: assert property ($fell(core_reset_o) |->
		$past(idle) && $past(idle, RST_SYNC_STAGES)) else $error("reset released too early");
	chk_cfg_hold: assert property (settled |-> $stable(clk_cfg_o))
		else $error("settings changed outside reset");
	chk_pcix_little: assert property (settled |-> !clk_cfg_o.pcix_big_endian)
		else $error("pci side not little endian");
	chk_mem_clk: assert property ($past(!sys_rst_i) |-> mem_domain_clk_o == $past(mem_ref_clk_i))
		else $error("memory domain clock lost its reference");
	chk_timer_clk: assert property ($past(!sys_rst_i) |->
		timer_count_clk_o == $past(timer_ext_clk_i)) else $error("timer clock not routed");
	chk_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("bus answer not ready okay");
endmodule : bscrc_top_sva

/* File: sim/bscrc_board_model.sv */
// board supervisor model: reference clocks and power good
// assumes the bench drives straps and reset pins itself
`timescale 1ns/1ps
module bscrc_board_model
(
	input wire logic sys_clk_i,
	input wire logic pg_drop_i,
	output logic power_good_o = 1'b0,
	output logic mem_ref_clk_o = 1'b0,
	output logic timer_ext_clk_o = 1'b0
);
	logic [3:0] settle = 4'h0;
	logic [1:0] tdiv = 2'h0;
	// reference clocks run free, so they are seen as sampled levels
	always @(posedge sys_clk_i)
	begin
		mem_ref_clk_o <= ~mem_ref_clk_o;
		tdiv <= tdiv + 2'h1;
		timer_ext_clk_o <= tdiv[1];
	end
	// power good only after supply and clocks have settled for eight cycles
	always @(posedge sys_clk_i)
	begin
		settle <= pg_drop_i ? 4'h0 : settle + {3'h0, settle != 4'hf};
		power_good_o <= !pg_drop_i && settle >= 4'h8;
	end
endmodule : bscrc_board_model

/* File: sim/boot_strap_clock_reset_config_tb.sv */
// bench for the strap front end: bus reads, pin resets, strap sweep
// assumes the package, design, board model and checker are compiled first
`timescale 1ns/1ps
module boot_strap_clock_reset_config_tb
	import bscrc_pkg::*;
;
	logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, warm_reset_n_i = 1'b1;
	logic full_init_reset_n_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, pg_drop = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd, hrdata_o;
	wire logic power_good_i, timer_ext_clk_i, mem_ref_clk_i, hready_i;
	wire logic [1:0] mem_ratio_strap_i, localbus_ratio_strap_i;
	wire logic [2:0] pipe_ratio_strap_i;
	wire logic byte_order_strap_i, response_order_strap_i;
	logic hreadyout_o, hresp_o, core_reset_o, mem_if_reset_o, timer_count_clk_o, mem_domain_clk_o;
	bscrc_clkcfg_t clk_cfg_o;
	bscrc_straps_t st = '{2'h2, 2'h1, 3'h0, 1'b0, 1'b1};
	int mismatches = 0, n_compared = 0;
	localparam logic [2:0] MH[4] = '{BSCRC_HALF_DIV1, BSCRC_HALF_DIV2, BSCRC_HALF_DIV1P5, 3'h0};
	localparam logic [2:0] VC[4] = '{BSCRC_VCO_X3, BSCRC_VCO_X4, BSCRC_VCO_X3, 3'h0};
	localparam logic [3:0] LB[4] = '{BSCRC_LB_9, BSCRC_LB_12, BSCRC_LB_15, 4'h0};
	// one slave, so its ready is the bus ready
	assign hready_i = hreadyout_o;
	assign {mem_ratio_strap_i, localbus_ratio_strap_i, pipe_ratio_strap_i,
		byte_order_strap_i, response_order_strap_i} = st;
	always #50 sys_clk_i = ~sys_clk_i;
	bscrc_board_model i_board (.sys_clk_i(sys_clk_i), .pg_drop_i(pg_drop),
		.power_good_o(power_good_i), .mem_ref_clk_o(mem_ref_clk_i),
		.timer_ext_clk_o(timer_ext_clk_i));
	bscrc_top #(.RST_SYNC_STAGES(2)) i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.warm_reset_n_i(warm_reset_n_i), .full_init_reset_n_i(full_init_reset_n_i),
		.power_good_i(power_good_i), .mem_ratio_strap_i(mem_ratio_strap_i),
		.localbus_ratio_strap_i(localbus_ratio_strap_i),
		.pipe_ratio_strap_i(pipe_ratio_strap_i), .byte_order_strap_i(byte_order_strap_i),
		.response_order_strap_i(response_order_strap_i), .timer_ext_clk_i(timer_ext_clk_i),
		.mem_ref_clk_i(mem_ref_clk_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.hrdata_o(hrdata_o), .core_reset_o(core_reset_o), .mem_if_reset_o(mem_if_reset_o),
		.clk_cfg_o(clk_cfg_o), .timer_count_clk_o(timer_count_clk_o),
		.mem_domain_clk_o(mem_domain_clk_o));
	function automatic bscrc_clkcfg_t exp_cfg(input bscrc_straps_t s);
		return '{MH[s.mem_ratio_strap], VC[s.mem_ratio_strap], LB[s.localbus_ratio_strap],
			BSCRC_PIPE_HALF_BASE + 4'(s.pipe_ratio_strap), s.byte_order_strap,
			~s.response_order_strap, 1'b0, s.mem_ratio_strap == 2'h3 || s.localbus_ratio_strap == 2'h3};
	endfunction : exp_cfg
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// samples before each edge, so the edge's own updates never race the bench
	task automatic until_ok(input logic bus, input logic lvl);
		int n;
		logic ok;
		n = 0;
		do
		begin
			@(negedge sys_clk_i);
			ok = bus ? hreadyout_o === 1'b1 : core_reset_o === lvl;
			rd = hrdata_o;
			n++;
			@(posedge sys_clk_i);
		end
		while (!ok && n < 60);
		if (!ok)
		begin
			mismatches++;
			report_and_stop();
		end
	endtask : until_ok
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		until_ok(1'b1, 1'b0);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		until_ok(1'b1, 1'b0);
	endtask : ahb
	task automatic check_resets(input logic [31:0] exp);
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
		cmp({30'h0, core_reset_o, mem_if_reset_o}, exp);
		@(posedge sys_clk_i);
	endtask : check_resets
	// main sequence: boot, register checks, strap sweep, warm, soft and power resets
	initial
	begin
		repeat (4) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		until_ok(1'b0, 1'b0);
		ahb(1'b0, BSCRC_RATIO_OFS, 32'h0);
		cmp(rd, 32'h00004c33);
		st <= '{2'h1, 2'h2, 3'h7, 1'b1, 1'b0};
		ahb(1'b1, BSCRC_STATUS_OFS, 32'hffffffff);
		ahb(1'b0, BSCRC_STATUS_OFS, 32'h0);
		cmp(rd, 32'h00000906);
		ahb(1'b0, 8'h10, 32'h0);
		cmp(rd, 32'h0);
		ahb(1'b0, BSCRC_CTRL_OFS, 32'h0);
		cmp(rd, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			st <= '{2'(i), 2'(i + 1), 3'(i), i[0], i[1]};
			full_init_reset_n_i <= 1'b0;
			check_resets(32'h3);
			full_init_reset_n_i <= 1'b1;
			until_ok(1'b0, 1'b0);
			@(negedge sys_clk_i);
			cmp(32'(clk_cfg_o), 32'(exp_cfg(st)));
			@(posedge sys_clk_i);
		end
		warm_reset_n_i <= 1'b0;
		check_resets(32'h2);
		warm_reset_n_i <= 1'b1;
		until_ok(1'b0, 1'b0);
		ahb(1'b1, BSCRC_CTRL_OFS, 32'h1 << BSCRC_CTRL_SOFT_WARM);
		until_ok(1'b0, 1'b1);
		@(negedge sys_clk_i);
		cmp({30'h0, core_reset_o, mem_if_reset_o}, 32'h2);
		until_ok(1'b0, 1'b0);
		// soft cold reset must reset both domains and recapture changed straps
		st <= '{2'h0, 2'h2, 3'h3, 1'b1, 1'b0};
		ahb(1'b1, BSCRC_CTRL_OFS, 32'h1 << BSCRC_CTRL_SOFT_COLD);
		until_ok(1'b0, 1'b1);
		@(negedge sys_clk_i);
		cmp({30'h0, core_reset_o, mem_if_reset_o}, 32'h3);
		until_ok(1'b0, 1'b0);
		@(negedge sys_clk_i);
		cmp(32'(clk_cfg_o), 32'(exp_cfg(st)));
		@(posedge sys_clk_i);
		pg_drop <= 1'b1;
		@(posedge sys_clk_i);
		check_resets(32'h3);
		pg_drop <= 1'b0;
		until_ok(1'b0, 1'b0);
		report_and_stop();
	end
endmodule : boot_strap_clock_reset_config_tb
bind bscrc_top bscrc_top_sva #(.RST_SYNC_STAGES(RST_SYNC_STAGES)) i_sva (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .warm_reset_n_i(warm_reset_n_i),
	.full_init_reset_n_i(full_init_reset_n_i), .power_good_i(power_good_i),
	.timer_ext_clk_i(timer_ext_clk_i), .mem_ref_clk_i(mem_ref_clk_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .core_reset_o(core_reset_o),
	.mem_if_reset_o(mem_if_reset_o), .clk_cfg_o(clk_cfg_o),
	.timer_count_clk_o(timer_count_clk_o), .mem_domain_clk_o(mem_domain_clk_o));
